// *** hdl/current_seq_pkg.sv ***
package current_seq_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0]  HOLD_RUN_INDEX      = 8'h47;
    localparam logic [7:0]  POWER_DOWN_INDEX    = 8'h48;
    localparam logic [7:0]  CTRL_INDEX          = 8'h50;
    localparam logic [7:0]  STATUS_INDEX        = 8'h51;
    localparam logic [11:0] HOLD_RUN_ADDR       = 12'h11c;
    localparam logic [11:0] POWER_DOWN_ADDR     = 12'h120;
    localparam logic [11:0] CTRL_ADDR           = 12'h140;
    localparam logic [11:0] STATUS_ADDR         = 12'h144;

    // Field positions of the hold/run current register.
    localparam int          RUN_DLY_LSB         = 24;
    localparam int          HOLD_DLY_LSB        = 16;
    localparam int          RUN_LVL_LSB         = 8;
    localparam int          HOLD_LVL_LSB        = 0;
    // Field positions of the status and control registers.
    localparam int          ST_LEVEL_LSB        = 0;
    localparam int          ST_STATE_LSB        = 8;
    localparam int          ST_PERMIT_BIT       = 16;
    localparam int          ST_FREE_BIT         = 17;
    localparam int          ST_SHORT_BIT        = 18;
    localparam int          CTRL_SHORT_BIT      = 0;

    // Reset values.
    localparam logic [3:0]  RUN_DLY_RESET       = 4'h4;
    localparam logic [3:0]  HOLD_DLY_RESET      = 4'h1;
    localparam logic [4:0]  RUN_LVL_RESET       = 5'h1f;
    localparam logic [4:0]  HOLD_LVL_RESET      = 5'h08;
    localparam logic [7:0]  WAIT_TIME_RESET     = 8'h0a;
    localparam logic        SHORT_SEL_RESET     = 1'b0;

    // Timing: the pclk rate in Hz, then step and wait units in clock cycles of pclk.
    localparam int unsigned CLK_HZ              = 20_000_000;
    localparam int unsigned RUN_STEP_UNIT       = 512;
    localparam int unsigned HOLD_STEP_UNIT      = 2 ** 18;
    localparam int unsigned WAIT_UNIT           = 2 ** 18;
    localparam int          TIMER_W             = 27;

    typedef enum logic [4:0] {
        ST_HOLD      = 5'h01,
        ST_RAMP_UP   = 5'h02,
        ST_RUN       = 5'h04,
        ST_WAIT      = 5'h08,
        ST_RAMP_DOWN = 5'h10
    } seq_state_t;

endpackage : current_seq_pkg

// *** hdl/step_interval_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

module step_interval_timer #(
    parameter int W = 27
) (
    input  wire logic         pclk,     // Block clock.
    input  wire logic         presetn,  // Asynchronous reset, active low.
    input  wire logic         start,    // Loads a new interval, overriding any running one.
    input  wire logic [W-1:0] cycles,   // Interval length minus one, taken with start.
    output logic              done      // High for one cycle when the interval ends.
);
    typedef struct packed {
        logic         busy;
        logic [W-1:0] count;
    } timer_t;

    timer_t s;
    timer_t next_s;

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.busy  = 1'b1;
            next_s.count = cycles - W'(1);
        end else if (s.busy) begin
            if (s.count == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.count = s.count - W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.busy && (s.count == '0);

endmodule : step_interval_timer

`default_nettype wire

// *** hdl/motor_current_hold_run_sequencer.sv ***
// Operation
// - Run step lasts delay times 512; zero instant
// - Reach run current before motion is permitted
// - Power-down only after standstill and wait elapsed
// - Hold step lasts delay times 2^18; zero instant
// - Level code n means (n+1)/32 full scale
// - Zero hold level under voltage PWM: freewheel/short
// - Standstill wait is value times 2^18, reset 0x0a
`timescale 1ns/1ns
`default_nettype none

module motor_current_hold_run_sequencer #(
    parameter int unsigned HOLD_UNIT_CYCLES = current_seq_pkg::HOLD_STEP_UNIT,
    parameter int unsigned WAIT_UNIT_CYCLES = current_seq_pkg::WAIT_UNIT
) (
    input  wire logic        pclk,              // Block clock, 20 MHz.
    input  wire logic        presetn,           // Asynchronous reset, active low.
    input  wire logic        psel,              // APB select.
    input  wire logic        penable,           // APB enable.
    input  wire logic        pwrite,            // APB direction, high for write.
    input  wire logic [11:0] paddr,             // APB byte address.
    input  wire logic [31:0] pwdata,            // APB write data.
    input  wire logic [3:0]  pstrb,             // APB byte strobes.
    output logic             pready,            // APB ready.
    output logic [31:0]      prdata,            // APB read data.
    output logic             pslverr,           // APB error on unmapped address.
    input  wire logic        motion_request,    // Motion controller wants to move.
    input  wire logic        standstill,        // Standstill detected.
    input  wire logic        voltage_pwm_active,// Voltage-mode chopper in use.
    output logic             motion_permit,     // Run current reached, motion may start.
    output logic [4:0]       current_level,     // Current setpoint code.
    output logic [5:0]       current_32nds,     // Setpoint in 32nds of full scale.
    output logic             coil_freewheel,    // Bridges open at standstill.
    output logic             coil_short         // Coils shorted at standstill.
);
    import current_seq_pkg::*;

    typedef struct packed {
        logic [3:0]         run_dly;
        logic [3:0]         hold_dly;
        logic [4:0]         run_current_level;
        logic [4:0]         standstill_current_level;
        logic [7:0]         wait_time;
        logic               short_sel;
        seq_state_t         st;
        logic [4:0]         level;
        logic [5:0]         level_32;
        logic               permit;
        logic               freewheel;
        logic               shorted;
        logic               tstart;
        logic [TIMER_W-1:0] tlen;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
    } seq_t;

    seq_t s;
    seq_t next_s;
    logic timer_done;

    // Interval of mult units, minus one for the timer's load convention.
    function automatic logic [TIMER_W-1:0] interval(input logic [7:0] mult, input int unsigned unit);
        logic [63:0] prod;
        prod = 64'(mult) * 64'(unit);
        return TIMER_W'(prod - 64'h1);
    endfunction : interval

    // Moves a level one code toward its target.
    function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] target);
        logic [4:0] r;
        r = cur;
        if (cur < target) begin
            r = cur + 5'h1;
        end else if (cur > target) begin
            r = cur - 5'h1;
        end
        return r;
    endfunction : step_toward

    // Applies byte strobes so that a partial write leaves the other bytes alone.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Packs the configuration fields into their bus positions, for reads and merges alike.
    function automatic logic [31:0] hold_run_word(input seq_t v);
        logic [31:0] r;
        r = 32'h0;
        r[RUN_DLY_LSB +: 4]  = v.run_dly;
        r[HOLD_DLY_LSB +: 4] = v.hold_dly;
        r[RUN_LVL_LSB +: 5]  = v.run_current_level;
        r[HOLD_LVL_LSB +: 5] = v.standstill_current_level;
        return r;
    endfunction : hold_run_word

    always_comb begin
        logic        acc;
        logic        done_ok;
        logic [31:0] w;
        logic        coast;
        acc     = 1'b0;
        done_ok = 1'b0;
        w       = 32'h0;
        coast   = 1'b0;
        next_s  = s;
        next_s.tstart = 1'b0;

        // Register bus: answer in the access cycle right after setup.
        // The error flag stands only with pready, so a master must take it at that edge.
        next_s.pready  = psel && !penable;
        next_s.pslverr = 1'b0;
        if (psel && !penable) begin
            next_s.prdata = 32'h0;
            if (paddr == HOLD_RUN_ADDR) begin
                next_s.prdata = hold_run_word(s);
            end else if (paddr == POWER_DOWN_ADDR) begin
                next_s.prdata[7:0] = s.wait_time;
            end else if (paddr == CTRL_ADDR) begin
                next_s.prdata[CTRL_SHORT_BIT] = s.short_sel;
            end else if (paddr == STATUS_ADDR) begin
                next_s.prdata[ST_LEVEL_LSB +: 5] = s.level;
                next_s.prdata[ST_STATE_LSB +: 5] = s.st;
                next_s.prdata[ST_PERMIT_BIT]     = s.permit;
                next_s.prdata[ST_FREE_BIT]       = s.freewheel;
                next_s.prdata[ST_SHORT_BIT]      = s.shorted;
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        acc = psel && penable && s.pready;
        if (acc) begin
            next_s.pready = 1'b0;
        end
        if (acc && pwrite) begin
            if (paddr == HOLD_RUN_ADDR) begin
                w = merge(hold_run_word(s), pwdata, pstrb);
                next_s.run_dly  = w[RUN_DLY_LSB +: 4];
                next_s.hold_dly = w[HOLD_DLY_LSB +: 4];
                next_s.run_current_level     = w[RUN_LVL_LSB +: 5];
                next_s.standstill_current_level    = w[HOLD_LVL_LSB +: 5];
            end else if (paddr == POWER_DOWN_ADDR) begin
                if (pstrb[0]) begin
                    next_s.wait_time = pwdata[7:0];
                end
            end else if (paddr == CTRL_ADDR) begin
                if (pstrb[0]) begin
                    next_s.short_sel = pwdata[CTRL_SHORT_BIT];
                end
            end
        end

        // A done seen while a restart is in flight belongs to the old interval.
        done_ok = timer_done && !s.tstart;

        // The sequencer works on the settings held before this cycle's write.
        case (s.st)
            ST_HOLD: begin
                if (motion_request) begin
                    if (s.run_dly == 4'h0 || s.level == s.run_current_level) begin
                        next_s.level = s.run_current_level;
                        next_s.st    = ST_RUN;
                    end else begin
                        next_s.st     = ST_RAMP_UP;
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(8'(s.run_dly), RUN_STEP_UNIT);
                    end
                end else begin
                    next_s.level = s.standstill_current_level;
                end
            end
            ST_RAMP_UP: begin
                if (s.run_dly == 4'h0) begin
                    next_s.level = s.run_current_level;
                    next_s.st    = ST_RUN;
                end else if (done_ok) begin
                    next_s.level = step_toward(s.level, s.run_current_level);
                    if (next_s.level == s.run_current_level) begin
                        next_s.st = ST_RUN;
                    end else begin
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(8'(s.run_dly), RUN_STEP_UNIT);
                    end
                end
            end
            ST_RUN: begin
                next_s.level = s.run_current_level;
                if (standstill && !motion_request) begin
                    next_s.st = ST_WAIT;
                    if (s.wait_time != 8'h0) begin
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(s.wait_time, WAIT_UNIT_CYCLES);
                    end
                end
            end
            ST_WAIT: begin
                next_s.level = s.run_current_level;
                // A lost standstill cancels the wait; the timer left running is simply ignored.
                if (motion_request || !standstill) begin
                    next_s.st = ST_RUN;
                end else if (s.wait_time == 8'h0 || done_ok) begin
                    if (s.hold_dly == 4'h0) begin
                        next_s.level = s.standstill_current_level;
                        next_s.st    = ST_HOLD;
                    end else begin
                        next_s.st     = ST_RAMP_DOWN;
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(8'(s.hold_dly), HOLD_UNIT_CYCLES);
                    end
                end
            end
            ST_RAMP_DOWN: begin
                // Motion wins over the power-down ramp; the climb starts from the present level.
                if (motion_request) begin
                    if (s.run_dly == 4'h0 || s.level == s.run_current_level) begin
                        next_s.level = s.run_current_level;
                        next_s.st    = ST_RUN;
                    end else begin
                        next_s.st     = ST_RAMP_UP;
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(8'(s.run_dly), RUN_STEP_UNIT);
                    end
                end else if (s.hold_dly == 4'h0) begin
                    next_s.level = s.standstill_current_level;
                    next_s.st    = ST_HOLD;
                end else if (done_ok) begin
                    next_s.level = step_toward(s.level, s.standstill_current_level);
                    if (next_s.level == s.standstill_current_level) begin
                        next_s.st = ST_HOLD;
                    end else begin
                        next_s.tstart = 1'b1;
                        next_s.tlen   = interval(8'(s.hold_dly), HOLD_UNIT_CYCLES);
                    end
                end
            end
            default: begin
                // An illegal code drops back to standstill current rather than keep a stale setpoint.
                next_s.st    = ST_HOLD;
                next_s.level = s.standstill_current_level;
            end
        endcase

        // Outputs follow the next state so that they all change on one edge.
        next_s.level_32  = {1'b0, next_s.level} + 6'h01;
        next_s.permit    = (next_s.st == ST_RUN) || (next_s.st == ST_WAIT);
        // Freewheel and short share one condition; the select bit only picks which, so never both.
        coast            = voltage_pwm_active && (next_s.st == ST_HOLD) && (next_s.standstill_current_level == 5'h0);
        next_s.freewheel = coast && !next_s.short_sel;
        next_s.shorted   = coast && next_s.short_sel;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s           <= '0;
            s.run_dly   <= RUN_DLY_RESET;
            s.hold_dly  <= HOLD_DLY_RESET;
            s.run_current_level      <= RUN_LVL_RESET;
            s.standstill_current_level     <= HOLD_LVL_RESET;
            s.wait_time <= WAIT_TIME_RESET;
            s.short_sel <= SHORT_SEL_RESET;
            s.st        <= ST_HOLD;
            s.level     <= HOLD_LVL_RESET;
            // The scaled setpoint starts consistent with the reset hold level.
            s.level_32  <= {1'b0, HOLD_LVL_RESET} + 6'h01;
        end else begin
            s <= next_s;
        end
    end

    // One timer serves the wait and both ramps, since only one of them runs at a time.
    step_interval_timer #(
        .W (TIMER_W)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (s.tstart),
        .cycles  (s.tlen),
        .done    (timer_done)
    );

    assign pready         = s.pready;
    assign prdata         = s.prdata;
    assign pslverr        = s.pslverr;
    assign motion_permit  = s.permit;
    assign current_level  = s.level;
    assign current_32nds  = s.level_32;
    assign coil_freewheel = s.freewheel;
    assign coil_short     = s.shorted;

endmodule : motor_current_hold_run_sequencer

`default_nettype wire

// *** tb/current_seq_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module current_seq_chk
    import current_seq_pkg::*;
#(
    parameter int unsigned HOLD_UNIT_CYCLES = 16,
    parameter int unsigned WAIT_UNIT_CYCLES = 16
) (
    input wire logic        pclk,           // Clock.
    input wire logic        presetn,        // Reset, active low.
    input wire logic        psel,           // Select.
    input wire logic        penable,        // Enable.
    input wire logic        pwrite,         // Direction.
    input wire logic [11:0] paddr,          // Address.
    input wire logic [31:0] pwdata,         // Write data.
    input wire logic [3:0]  pstrb,          // Strobes.
    input wire logic        pready,         // Ready.
    input wire logic [31:0] prdata,         // Read data.
    input wire logic        pslverr,        // Error.
    input wire logic        standstill,     // Motor still.
    input wire logic        voltage_pwm_active, // Voltage chopper.
    input wire logic        motion_permit,  // Run reached.
    input wire logic [4:0]  current_level,  // Level code.
    input wire logic [5:0]  current_32nds,  // Scaled level.
    input wire logic        coil_freewheel, // Bridges open.
    input wire logic        coil_short      // Coils shorted.
);
    logic [4:0]  run_lvl;
    logic [7:0]  wait_val;
    logic [31:0] still_cnt;
    logic        wr_done;
    logic        setup;
    logic        mapped;
    assign wr_done = psel && penable && pready && pwrite;
    assign setup = psel && !penable;
    assign mapped = paddr inside {HOLD_RUN_ADDR, POWER_DOWN_ADDR, CTRL_ADDR, STATUS_ADDR};

    // Shadows of the fields the assertions depend on, updated at the edge a write lands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_lvl   <= RUN_LVL_RESET;
            wait_val  <= WAIT_TIME_RESET;
            still_cnt <= 32'h0;
        end else begin
            if (wr_done && paddr == HOLD_RUN_ADDR && pstrb[1]) run_lvl <= pwdata[RUN_LVL_LSB +: 5];
            if (wr_done && paddr == POWER_DOWN_ADDR && pstrb[0]) wait_val <= pwdata[7:0];
            still_cnt <= standstill ? still_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_level_scale: assert property (current_32nds == {1'b0, current_level} + 6'h01)
        else $error("setpoint scale wrong");
    a_permit_run_level: assert property (motion_permit |-> current_level == $past(run_lvl))
        else $error("motion permitted below run level");
    a_freewheel_cause: assert property (coil_freewheel |-> !motion_permit && current_level == 5'h00 && $past(voltage_pwm_active))
        else $error("freewheel without cause");
    a_coil_exclusive: assert property (!(coil_freewheel && coil_short))
        else $error("freewheel and short together");
    a_wait_elapsed: assert property ($fell(motion_permit) |-> still_cnt >= WAIT_UNIT_CYCLES * wait_val)
        else $error("power-down before standstill wait elapsed");

    c_permit_up: cover property ($rose(motion_permit));
    c_permit_down: cover property ($fell(motion_permit));
    c_short: cover property (coil_short);
    c_refused: cover property (pslverr);
endmodule : current_seq_chk

bind motor_current_hold_run_sequencer current_seq_chk #(
    .HOLD_UNIT_CYCLES(HOLD_UNIT_CYCLES), .WAIT_UNIT_CYCLES(WAIT_UNIT_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .standstill(standstill), .voltage_pwm_active(voltage_pwm_active), .motion_permit(motion_permit),
    .current_level(current_level), .current_32nds(current_32nds), .coil_freewheel(coil_freewheel),
    .coil_short(coil_short)
);
`default_nettype wire

// *** tb/motor_load_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module motor_load_model (
    input  wire logic pclk,          // Clock.
    input  wire logic presetn,       // Reset, active low.
    input  wire logic move,          // Motion wanted.
    input  wire logic motion_permit, // Run current reached.
    output logic      standstill     // Rotor at rest.
);
    logic [2:0] quiet;

    // The rotor settles a few cycles after the last step, so standstill lags the stop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet      <= 3'h7;
            standstill <= 1'b1;
        end else if (move && motion_permit) begin
            quiet      <= 3'h0;
            standstill <= 1'b0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end else begin
            standstill <= 1'b1;
        end
    end
endmodule : motor_load_model
`default_nettype wire

// *** tb/test_motor_current_hold_run_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_motor_current_hold_run_sequencer;
    import current_seq_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        motion_request = 1'b0;
    logic        voltage_pwm_active = 1'b0;
    logic        pready, pslverr, standstill, motion_permit, coil_freewheel, coil_short;
    logic [31:0] prdata, rd;
    logic [4:0]  current_level;
    logic [5:0]  current_32nds;
    logic        er;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;

    motor_current_hold_run_sequencer #(.HOLD_UNIT_CYCLES(16), .WAIT_UNIT_CYCLES(16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .motion_request(motion_request), .standstill(standstill),
        .voltage_pwm_active(voltage_pwm_active), .motion_permit(motion_permit),
        .current_level(current_level), .current_32nds(current_32nds),
        .coil_freewheel(coil_freewheel), .coil_short(coil_short));
    motor_load_model load (.pclk(pclk), .presetn(presetn), .move(motion_request),
        .motion_permit(motion_permit), .standstill(standstill));

    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic wrap_up;
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hf);
        chk(what, exp, rd);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask : rdchk

    // Counts edges until motion_permit takes the given level, sampling after each edge settles.
    task automatic wait_permit(input logic v);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (motion_permit !== v && n < 8000);
    endtask : wait_permit

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("current_32nds", 32'h9, {26'h0, current_32nds});
        rdchk("hold_run_current_config", HOLD_RUN_ADDR, 32'h0401_1f08);
        rdchk("standstill_power_down_delay", POWER_DOWN_ADDR, 32'h0000_000a);
        rdchk("ctrl", CTRL_ADDR, 32'h0);
        rdchk("status", STATUS_ADDR, 32'h0000_0108);
        apb(1'b1, STATUS_ADDR, 32'hffff_ffff, 4'hf);
        chk("pslverr", 32'h0, {31'h0, er});
        apb(1'b1, POWER_DOWN_ADDR, 32'h0000_0077, 4'h0);
        rdchk("standstill_power_down_delay", POWER_DOWN_ADDR, 32'h0000_000a);
        apb(1'b1, POWER_DOWN_ADDR, 32'h0000_0002, 4'hf);
        rdchk("standstill_power_down_delay", POWER_DOWN_ADDR, 32'h0000_0002);
        apb(1'b0, 12'h200, 32'h0, 4'hf);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("prdata", 32'h0, rd);
        apb(1'b1, HOLD_RUN_ADDR, 32'h0101_1408, 4'hf);
        rdchk("hold_run_current_config", HOLD_RUN_ADDR, 32'h0101_1408);
        // Twelve steps of 512 cycles from level 8 to level 20.
        @(posedge pclk);
        motion_request <= 1'b1;
        wait_permit(1'b1);
        chk("ramp_up_cycles", 32'h1801, n);
        chk("current_level", 32'h14, {27'h0, current_level});
        chk("current_32nds", 32'h15, {26'h0, current_32nds});
        rdchk("status", STATUS_ADDR, 32'h0001_0414);
        // Stop: wait of 2 units of 16, then steps of 16 cycles.
        @(posedge pclk);
        motion_request <= 1'b0;
        wait_permit(1'b0);
        chk("wait_elapsed", 32'h1, {31'h0, n >= 33 && n <= 48});
        repeat (24) @(posedge pclk);
        #1;
        chk("current_level", 32'h13, {27'h0, current_level});
        repeat (16) @(posedge pclk);
        #1;
        chk("current_level", 32'h12, {27'h0, current_level});
        // Motion during the power-down ramp climbs back two steps.
        @(posedge pclk);
        motion_request <= 1'b1;
        wait_permit(1'b1);
        chk("abort_ramp_cycles", 32'h401, n);
        chk("current_level", 32'h14, {27'h0, current_level});
        apb(1'b1, HOLD_RUN_ADDR, 32'h0000_1400, 4'hf);
        apb(1'b1, POWER_DOWN_ADDR, 32'h0000_0000, 4'hf);
        @(posedge pclk);
        motion_request <= 1'b0;
        wait_permit(1'b0);
        chk("current_level", 32'h0, {27'h0, current_level});
        chk("current_32nds", 32'h1, {26'h0, current_32nds});
        @(posedge pclk);
        voltage_pwm_active <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("coils", 32'h2, {30'h0, coil_freewheel, coil_short});
        apb(1'b1, CTRL_ADDR, 32'h0000_0001, 4'hf);
        repeat (2) @(posedge pclk);
        #1;
        chk("coils", 32'h1, {30'h0, coil_freewheel, coil_short});
        @(posedge pclk);
        voltage_pwm_active <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk("coils", 32'h0, {30'h0, coil_freewheel, coil_short});
        @(posedge pclk);
        motion_request <= 1'b1;
        wait_permit(1'b1);
        chk("instant_run_cycles", 32'h1, n);
        chk("current_level", 32'h14, {27'h0, current_level});
        wrap_up();
    end
endmodule : test_motor_current_hold_run_sequencer
`default_nettype wire
